// ==== hw/pdio_defines.svh ====
// register map, field positions, reset values and timing counts of the digital pin block
`ifndef PDIO_DEFINES_SVH
`define PDIO_DEFINES_SVH
`define PDIO_AW 8
`define PDIO_CTRL_OFF 8'h00
`define PDIO_P1PER_OFF 8'h04
`define PDIO_P1DUTY_OFF 8'h08
`define PDIO_P2PER_OFF 8'h0c
`define PDIO_P2DUTY_OFF 8'h10
`define PDIO_STAT_OFF 8'h14
`define PDIO_CMD_OFF 8'h18
`define PDIO_CF_FUNC 0
`define PDIO_CF_INV 2
`define PDIO_CF_VAL 3
`define PDIO_CF_PWM 4
`define PDIO_CF_P2 8
`define PDIO_CTRL_MASK 32'h0000_1f1f
`define PDIO_CTRL_RST 32'h0000_0000
`define PDIO_PWM_RST 32'h0000_0000
`define PDIO_ST_P1LVL 0
`define PDIO_ST_P2LVL 1
`define PDIO_ST_PROT 2
`define PDIO_ST_EMIT 3
`define PDIO_ST_CLRSEEN 4
`define PDIO_CMD_CLRPROT 0
`define PDIO_RESP_OK 2'b00
`define PDIO_RESP_SLVERR 2'b10
`define PDIO_PULSE_MIN_NS 30000
`define PDIO_CLK_NS 10
`define PDIO_PULSE_CYC ((`PDIO_PULSE_MIN_NS + `PDIO_CLK_NS - 1) / `PDIO_CLK_NS)
`define PDIO_CNT_W 12
`endif

// ==== hw/pdio_pkg.sv ====
// types shared by the digital pin block
`include "pdio_defines.svh"
package pdio_pkg;
	typedef enum logic [2:0] {
		PDIO_FN_DEF = 3'b001,
		PDIO_FN_IN = 3'b010,
		PDIO_FN_OUT = 3'b100
	} pdio_func_e;
	typedef enum logic [1:0] {
		PDIO_EM_IDLE = 2'b01,
		PDIO_EM_PULSE = 2'b10
	} pdio_emit_e;
	typedef logic [`PDIO_CNT_W-1:0] pdio_cnt_t;
	typedef struct packed {
		logic [2:0] sync;
		logic level;
		pdio_cnt_t cnt;
		logic pulse;
	} pdio_filt_s;
	typedef struct packed {
		logic [31:0] cnt;
		logic active;
	} pdio_pwm_s;
	typedef struct packed {
		logic awReady;
		logic wReady;
		logic awGot;
		logic wGot;
		logic [`PDIO_AW-1:0] awAddr;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bValid;
		logic [1:0] bResp;
		logic arReady;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
		logic [31:0] ctrl;
		logic [31:0] per1;
		logic [31:0] duty1;
		logic [31:0] per2;
		logic [31:0] duty2;
		logic prot;
		logic clrSeen;
		logic onPrev;
		pdio_emit_e emit;
		pdio_cnt_t emitCnt;
		logic pin1Out;
		logic pin1Oe;
		logic pin2Out;
		logic pin2Oe;
	} pdio_top_s;
endpackage : pdio_pkg

// ==== hw/pdio_pin_if.sv ====
// pin sample path between the top and a pin filter
`timescale 1ns/10ps
`default_nettype none
interface pdio_pin_if;
	logic pinIn;
	logic invert;
	logic level;
	logic validPulse;
	modport filt (input pinIn, input invert, output level, output validPulse);
	modport user (output pinIn, output invert, input level, input validPulse);
endinterface : pdio_pin_if
`default_nettype wire

// ==== hw/pdio_pin_filter.sv ====
// pin input synchroniser and active-level interval width qualifier (low, high when inverted)
`timescale 1ns/10ps
`default_nettype none
`include "pdio_defines.svh"
module pdio_pin_filter
	import pdio_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rstN,
	// pin sample path
	pdio_pin_if.filt pin
);
	localparam pdio_cnt_t PulseCyc = `PDIO_CNT_W'(`PDIO_PULSE_CYC);
	pdio_filt_s q;
	pdio_filt_s d;
	logic act;

	always_comb
	begin
		d = q;
		d.sync = {q.sync[1:0], pin.pinIn};
		if (q.sync[1] == q.sync[2])
		begin
			d.level = q.sync[2];
		end
		// pulse level is low, high when inverted
		act = (q.level == pin.invert);
		d.pulse = 1'b0;
		if (!act)
		begin
			d.cnt = '0;
		end
		else if (q.cnt != PulseCyc)
		begin
			d.cnt = q.cnt + 1'b1;
			d.pulse = (q.cnt == PulseCyc - 1'b1);
		end
	end

	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			q <= '{sync: 3'h7, level: 1'b1, cnt: '0, pulse: 1'b0};
		end
		else
		begin
			q <= d;
		end
	end

	assign pin.level = q.level;
	assign pin.validPulse = q.pulse;

	a_pulse_min_width: assert property (@(posedge clk) disable iff (!rstN)
		q.pulse |-> (q.cnt == PulseCyc) && $past(act))
		else $error("pulse accepted before minimum low width");
endmodule : pdio_pin_filter
`default_nettype wire

// ==== hw/pdio_pwm.sv ====
// pwm generator; active for duty cycles out of every period cycles
`timescale 1ns/10ps
`default_nettype none
module pdio_pwm
	import pdio_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rstN,
	// settings
	input wire logic en,
	input wire logic [31:0] period,
	input wire logic [31:0] duty,
	// waveform
	output logic active
);
	pdio_pwm_s q;
	pdio_pwm_s d;

	always_comb
	begin
		d = q;
		if (!en || period == 32'h0)
		begin
			d.cnt = '0;
			d.active = 1'b0;
		end
		else
		begin
			d.cnt = (q.cnt >= period - 32'h1) ? 32'h0 : q.cnt + 32'h1;
			d.active = (d.cnt < duty);
		end
	end

	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	assign active = q.active;

	a_pwm_off_idle: assert property (@(posedge clk) disable iff (!rstN)
		(!en || period == 32'h0 || duty == 32'h0) |=> !active)
		else $error("pwm active while disabled or zero duty");
endmodule : pdio_pwm
`default_nettype wire

// ==== hw/pdio_top.sv ====
// two-pin protection digital port with axi4-lite register access
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "pdio_defines.svh"
module pdio_top
	import pdio_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// axi4-lite write
	input wire logic [`PDIO_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [`PDIO_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// instrument state
	input wire logic protTrip,
	input wire logic outputOn,
	output logic protActive,
	// pins
	input wire logic pin1In,
	output logic pin1Out,
	output logic pin1Oe,
	input wire logic pin2In,
	output logic pin2Out,
	output logic pin2Oe
);
	localparam pdio_cnt_t PulseCyc = `PDIO_CNT_W'(`PDIO_PULSE_CYC);
	localparam int P2 = `PDIO_CF_P2;

	logic [1:0] rstPipe;
	logic rstN;
	pdio_top_s q;
	pdio_top_s d;
	pdio_func_e fn1;
	pdio_func_e fn2;
	logic inv1;
	logic inv2;
	logic pwmAct1;
	logic pwmAct2;
	logic cmdClr;
	logic statW1c;
	logic clrReq;
	logic onRise;

	pdio_pin_if pif1 ();
	pdio_pin_if pif2 ();

	// reset is released through two flops so all state leaves reset on one edge
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rstPipe <= 2'b00;
		end
		else
		begin
			rstPipe <= {rstPipe[0], 1'b1};
		end
	end
	assign rstN = rstPipe[1];

	// illegal code 3 falls back to the default function
	function automatic pdio_func_e decFunc(input logic [1:0] code);
		pdio_func_e f;
		unique case (code)
			2'h1: f = PDIO_FN_IN;
			2'h2: f = PDIO_FN_OUT;
			default: f = PDIO_FN_DEF;
		endcase
		return f;
	endfunction : decFunc

	function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction : mergeStrb

	assign fn1 = decFunc(q.ctrl[`PDIO_CF_FUNC +: 2]);
	assign fn2 = decFunc(q.ctrl[P2 + `PDIO_CF_FUNC +: 2]);
	assign inv1 = q.ctrl[`PDIO_CF_INV];
	assign inv2 = q.ctrl[P2 + `PDIO_CF_INV];

	assign pif1.pinIn = pin1In;
	assign pif1.invert = inv1;
	assign pif2.pinIn = pin2In;
	assign pif2.invert = inv2;

	pdio_pin_filter u_filt1 (
		.clk(core_clk),
		.rstN(rstN),
		.pin(pif1.filt)
	);

	pdio_pin_filter u_filt2 (
		.clk(core_clk),
		.rstN(rstN),
		.pin(pif2.filt)
	);

	pdio_pwm u_pwm1 (
		.clk(core_clk),
		.rstN(rstN),
		.en(fn1 == PDIO_FN_OUT && q.ctrl[`PDIO_CF_PWM]),
		.period(q.per1),
		.duty(q.duty1),
		.active(pwmAct1)
	);

	pdio_pwm u_pwm2 (
		.clk(core_clk),
		.rstN(rstN),
		.en(fn2 == PDIO_FN_OUT && q.ctrl[P2 + `PDIO_CF_PWM]),
		.period(q.per2),
		.duty(q.duty2),
		.active(pwmAct2)
	);

	always_comb
	begin
		d = q;
		cmdClr = 1'b0;
		statW1c = 1'b0;
		// write channel: address and data taken in either order
		if (s_axi_awvalid && q.awReady)
		begin
			d.awGot = 1'b1;
			d.awAddr = s_axi_awaddr;
			d.awReady = 1'b0;
		end
		if (s_axi_wvalid && q.wReady)
		begin
			d.wGot = 1'b1;
			d.wData = s_axi_wdata;
			d.wStrb = s_axi_wstrb;
			d.wReady = 1'b0;
		end
		if (q.awGot && q.wGot && !q.bValid)
		begin
			d.awGot = 1'b0;
			d.wGot = 1'b0;
			d.bValid = 1'b1;
			d.bResp = `PDIO_RESP_OK;
			unique case (q.awAddr)
				`PDIO_CTRL_OFF: d.ctrl = mergeStrb(q.ctrl, q.wData, q.wStrb) & `PDIO_CTRL_MASK;
				`PDIO_P1PER_OFF: d.per1 = mergeStrb(q.per1, q.wData, q.wStrb);
				`PDIO_P1DUTY_OFF: d.duty1 = mergeStrb(q.duty1, q.wData, q.wStrb);
				`PDIO_P2PER_OFF: d.per2 = mergeStrb(q.per2, q.wData, q.wStrb);
				`PDIO_P2DUTY_OFF: d.duty2 = mergeStrb(q.duty2, q.wData, q.wStrb);
				`PDIO_STAT_OFF: statW1c = q.wStrb[0] && q.wData[`PDIO_ST_CLRSEEN];
				`PDIO_CMD_OFF: cmdClr = q.wStrb[0] && q.wData[`PDIO_CMD_CLRPROT];
				default: d.bResp = `PDIO_RESP_SLVERR;
			endcase
		end
		if (q.bValid && s_axi_bready)
		begin
			d.bValid = 1'b0;
			d.awReady = 1'b1;
			d.wReady = 1'b1;
		end
		// read channel: one read at a time, data registered
		if (s_axi_arvalid && q.arReady)
		begin
			d.arReady = 1'b0;
			d.rValid = 1'b1;
			d.rResp = `PDIO_RESP_OK;
			d.rData = 32'h0;
			unique case (s_axi_araddr)
				`PDIO_CTRL_OFF: d.rData = q.ctrl;
				`PDIO_P1PER_OFF: d.rData = q.per1;
				`PDIO_P1DUTY_OFF: d.rData = q.duty1;
				`PDIO_P2PER_OFF: d.rData = q.per2;
				`PDIO_P2DUTY_OFF: d.rData = q.duty2;
				`PDIO_STAT_OFF:
				begin
					// input state reads as 1 while the valid level is present
					d.rData[`PDIO_ST_P1LVL] = (pif1.level == inv1);
					d.rData[`PDIO_ST_P2LVL] = (pif2.level == inv2);
					d.rData[`PDIO_ST_PROT] = q.prot;
					d.rData[`PDIO_ST_EMIT] = (q.emit == PDIO_EM_PULSE);
					d.rData[`PDIO_ST_CLRSEEN] = q.clrSeen;
				end
				`PDIO_CMD_OFF: d.rData = 32'h0;
				default: d.rResp = `PDIO_RESP_SLVERR;
			endcase
		end
		if (q.rValid && s_axi_rready)
		begin
			d.rValid = 1'b0;
			d.arReady = 1'b1;
		end

		// own emitted pulse is not taken back as a clear request
		clrReq = (fn1 == PDIO_FN_DEF && pif1.validPulse && q.emit == PDIO_EM_IDLE) || cmdClr;
		// a trip in the clearing cycle wins
		d.prot = protTrip || (q.prot && !clrReq);
		d.clrSeen = (fn1 == PDIO_FN_DEF && pif1.validPulse && q.emit == PDIO_EM_IDLE) || (q.clrSeen && !statW1c);

		d.onPrev = outputOn;
		onRise = outputOn && !q.onPrev;
		unique case (q.emit)
			PDIO_EM_IDLE:
			begin
				if (fn1 == PDIO_FN_DEF && onRise && !q.prot)
				begin
					d.emit = PDIO_EM_PULSE;
					d.emitCnt = '0;
				end
			end
			PDIO_EM_PULSE:
			begin
				// leaving clear mode cuts the pulse short; else stay until our own low has left the filter
				if (fn1 != PDIO_FN_DEF)
					d.emit = PDIO_EM_IDLE;
				else if (q.emitCnt != PulseCyc)
					d.emitCnt = q.emitCnt + 1'b1;
				else if (pif1.level != inv1)
					d.emit = PDIO_EM_IDLE;
			end
			default: d.emit = PDIO_EM_IDLE;
		endcase

		unique case (fn1)
			PDIO_FN_DEF:
			begin
				d.pin1Oe = (d.emit == PDIO_EM_PULSE && d.emitCnt != PulseCyc);
				d.pin1Out = inv1;
			end
			PDIO_FN_IN:
			begin
				d.pin1Oe = 1'b0;
				d.pin1Out = 1'b0;
			end
			PDIO_FN_OUT:
			begin
				d.pin1Oe = 1'b1;
				d.pin1Out = (q.ctrl[`PDIO_CF_PWM] ? !pwmAct1 : !q.ctrl[`PDIO_CF_VAL]) ^ inv1;
			end
		endcase
		unique case (fn2)
			PDIO_FN_DEF:
			begin
				d.pin2Oe = 1'b1;
				d.pin2Out = !q.prot ^ inv2;
			end
			PDIO_FN_IN:
			begin
				d.pin2Oe = 1'b0;
				d.pin2Out = 1'b0;
			end
			PDIO_FN_OUT:
			begin
				d.pin2Oe = 1'b1;
				d.pin2Out = (q.ctrl[P2 + `PDIO_CF_PWM] ? !pwmAct2 : !q.ctrl[P2 + `PDIO_CF_VAL]) ^ inv2;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			q <= '0;
			q.awReady <= 1'b1;
			q.wReady <= 1'b1;
			q.arReady <= 1'b1;
			q.ctrl <= `PDIO_CTRL_RST;
			q.per1 <= `PDIO_PWM_RST;
			q.duty1 <= `PDIO_PWM_RST;
			q.per2 <= `PDIO_PWM_RST;
			q.duty2 <= `PDIO_PWM_RST;
			q.emit <= PDIO_EM_IDLE;
			q.pin2Out <= 1'b1;
			q.pin2Oe <= 1'b1;
		end
		else
		begin
			q <= d;
		end
	end

	assign s_axi_awready = q.awReady;
	assign s_axi_wready = q.wReady;
	assign s_axi_bvalid = q.bValid;
	assign s_axi_bresp = q.bResp;
	assign s_axi_arready = q.arReady;
	assign s_axi_rvalid = q.rValid;
	assign s_axi_rdata = q.rData;
	assign s_axi_rresp = q.rResp;
	assign protActive = q.prot;
	assign pin1Out = q.pin1Out;
	assign pin1Oe = q.pin1Oe;
	assign pin2Out = q.pin2Out;
	assign pin2Oe = q.pin2Oe;

	// emitted pulse width, counted independently of the state machine
	pdio_cnt_t emitRun;
	always_ff @(posedge core_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			emitRun <= '0;
		end
		else
		begin
			emitRun <= (fn1 == PDIO_FN_DEF && pin1Oe) ? emitRun + 1'b1 : '0;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstN);

	sequence sTurnOn;
		fn1 == PDIO_FN_DEF && onRise && !q.prot && q.emit == PDIO_EM_IDLE;
	endsequence
	sequence sPulseOut;
		pin1Oe && pin1Out == inv1;
	endsequence

	a_emit_start: assert property (sTurnOn ##1 fn1 == PDIO_FN_DEF |-> sPulseOut)
		else $error("no pulse after output turned on");
	a_emit_width: assert property ($fell(pin1Oe) && fn1 == PDIO_FN_DEF && $past(fn1 == PDIO_FN_DEF)
		|-> emitRun == PulseCyc)
		else $error("emitted pulse width wrong");
	a_clear_pulse: assert property (fn1 == PDIO_FN_DEF && pif1.validPulse && q.emit == PDIO_EM_IDLE
		&& !protTrip |=> !protActive)
		else $error("valid pulse did not clear protection");
	a_trip_wins: assert property (protTrip |=> protActive)
		else $error("trip lost against clear");
	a_func_onehot: assert property ($onehot(fn1) && $onehot(fn2))
		else $error("pin function not exactly one");
	a_state_level: assert property (fn2 == PDIO_FN_DEF && $stable(fn2) |=>
		pin2Oe && pin2Out == ($past(!q.prot) ^ $past(inv2)))
		else $error("state pin level wrong");
	a_out_level: assert property (fn1 == PDIO_FN_OUT && !q.ctrl[`PDIO_CF_PWM] |=>
		pin1Oe && pin1Out == ($past(!q.ctrl[`PDIO_CF_VAL]) ^ $past(inv1)))
		else $error("output level wrong");
	a_pwm_level: assert property (fn2 == PDIO_FN_OUT && q.ctrl[P2 + `PDIO_CF_PWM] |=>
		pin2Out == ($past(!pwmAct2) ^ $past(inv2)))
		else $error("pwm level wrong");
	a_input_float: assert property (fn1 == PDIO_FN_IN ##1 fn1 == PDIO_FN_IN |-> !pin1Oe)
		else $error("pin driven in input mode");
	a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
endmodule : pdio_top
`default_nettype wire

// ==== verification/pdio_ext_inst.sv ====
// far-side instrument model on the two pins
`timescale 1ns/10ps
`default_nettype none
module pdio_ext_inst
(
	// clock
	input wire logic clk,
	// device pin drivers
	input wire logic oe1,
	input wire logic out1,
	input wire logic oe2,
	input wire logic out2,
	// resolved pin levels
	output logic wire1,
	output logic wire2
);
	logic drv1 = 1'b1;
	logic drv2 = 1'b1;
	int lowRun = 0;
	int lastLow = 0;
	// released lines follow the far-side drivers drv1 and drv2, which start high
	assign wire1 = oe1 ? out1 : drv1;
	assign wire2 = oe2 ? out2 : drv2;
	// length of the last low interval on pin one, in clocks
	always @(posedge clk)
	begin
		if (!wire1)
			lowRun <= lowRun + 1;
		else if (lowRun != 0)
		begin
			lastLow <= lowRun;
			lowRun <= 0;
		end
	end
	task automatic setPins(input logic v1, input logic v2);
		@(posedge clk);
		drv1 <= v1;
		drv2 <= v2;
	endtask : setPins
	// pulses fall from high and hold low n clocks
	task automatic lowPulse(input int n);
		@(posedge clk);
		drv1 <= 1'b0;
		repeat (n) @(posedge clk);
		drv1 <= 1'b1;
	endtask : lowPulse
endmodule : pdio_ext_inst
`default_nettype wire

// ==== verification/tb_pdio_top.sv ====
// self-checking bench of the two-pin digital port
`timescale 1ns/10ps
`default_nettype none
`include "pdio_defines.svh"
module tb_pdio_top;
	logic core_clk = 1'b0;
	logic arstN = 1'b0;
	logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
	logic [31:0] wData = 32'h0, rData;
	logic [3:0] wStrb = 4'h0;
	logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
	logic awReady, wReady, bValid, arReady, rValid;
	logic [1:0] bResp, rResp;
	logic protTrip = 1'b0, outputOn = 1'b0, protActive;
	logic pin1In, pin1Out, pin1Oe, pin2In, pin2Out, pin2Oe;
	int fails = 0;
	int checks = 0;
	// ctrl value, then {p1, p2, oe1, out1, oe2, out2}
	logic [37:0] rows [9] = '{{32'h0000_0000, 6'h33}, {32'h0000_0400, 6'h32}, {32'h0000_0e0a, 6'h3b},
		{32'h0000_0a0e, 6'h3e}, {32'h0000_0602, 6'h3e}, {32'h0000_0206, 6'h3b},
		{32'h0000_0101, 6'h10}, {32'h0000_0505, 6'h10}, {32'h0000_0303, 6'h33}};
	always #5 core_clk = ~core_clk;
	pdio_top DUT (.core_clk(core_clk), .arst_n(arstN), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
		.s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
		.s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
		.s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .protTrip(protTrip),
		.outputOn(outputOn), .protActive(protActive), .pin1In(pin1In), .pin1Out(pin1Out),
		.pin1Oe(pin1Oe), .pin2In(pin2In), .pin2Out(pin2Out), .pin2Oe(pin2Oe));
	pdio_ext_inst ext (.clk(core_clk), .oe1(pin1Oe), .out1(pin1Out), .oe2(pin2Oe), .out2(pin2Out),
		.wire1(pin1In), .wire2(pin2In));
	task automatic end_of_test();
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	task automatic chkBit(input logic got, input logic exp);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR %0t bit got %b expected %b", $time, got, exp);
		end
	endtask : chkBit
	task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR %0t word got %h expected %h", $time, got, exp);
		end
	endtask : chkWord
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc
	task automatic hung(input int n);
		if (n >= 50)
		begin
			fails++;
			$display("ERROR %0t handshake timed out", $time);
			end_of_test();
		end
	endtask : hung
	task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aT, wT, bT;
		logic [1:0] r;
		int n;
		n = 0;
		@(posedge core_clk);
		awAddr <= a;
		awValid <= 1'b1;
		wData <= d;
		wStrb <= 4'hf;
		wValid <= 1'b1;
		bReady <= 1'b1;
		do
		begin
			@(negedge core_clk);
			aT = awValid && awReady;
			wT = wValid && wReady;
			bT = bValid;
			r = bResp;
			@(posedge core_clk);
			if (aT)
				awValid <= 1'b0;
			if (wT)
				wValid <= 1'b0;
			if (bT)
				bReady <= 1'b0;
			n++;
		end while (!bT && n < 50);
		hung(n);
		chkWord({30'h0, r}, {30'h0, er});
	endtask : axiWr
	task automatic axiRd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		logic aT, rT;
		logic [1:0] r;
		int n;
		n = 0;
		@(posedge core_clk);
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		do
		begin
			@(negedge core_clk);
			aT = arValid && arReady;
			rT = rValid;
			r = rResp;
			d = rData;
			@(posedge core_clk);
			if (aT)
				arValid <= 1'b0;
			if (rT)
				rReady <= 1'b0;
			n++;
		end while (!rT && n < 50);
		hung(n);
		chkWord({30'h0, r}, {30'h0, er});
	endtask : axiRd
	// reset held 10 clocks, then the idle pin state is checked
	task automatic rstChk();
		logic [31:0] d;
		@(posedge core_clk);
		arstN <= 1'b0;
		repeat (10) @(posedge core_clk);
		arstN <= 1'b1;
		cyc(3);
		chkBit(pin1Oe, 1'b0);
		chkBit(pin2Oe, 1'b1);
		chkBit(pin2Out, 1'b1);
		chkBit(protActive, 1'b0);
		axiRd(`PDIO_CTRL_OFF, d, `PDIO_RESP_OK);
		chkWord(d, `PDIO_CTRL_RST);
		axiRd(`PDIO_P1PER_OFF, d, `PDIO_RESP_OK);
		chkWord(d, `PDIO_PWM_RST);
	endtask : rstChk
	task automatic pulseIn(input logic trip, input logic on);
		@(posedge core_clk);
		protTrip <= trip;
		outputOn <= on;
		@(posedge core_clk);
		protTrip <= 1'b0;
	endtask : pulseIn
	initial
	begin
		logic [31:0] ctl, d;
		logic [5:0] f;
		logic e1, e2;
		int cnt, n;
		rstChk();
		foreach (rows[i])
		begin
			{ctl, f} = rows[i];
			ext.setPins(f[5], f[4]);
			axiWr(`PDIO_CTRL_OFF, ctl, `PDIO_RESP_OK);
			cyc(8);
			chkBit(pin1Oe, f[3]);
			if (f[3])
				chkBit(pin1Out, f[2]);
			chkBit(pin2Oe, f[1]);
			if (f[1])
				chkBit(pin2Out, f[0]);
			e1 = f[3] ? f[2] : f[5];
			e2 = f[1] ? f[0] : f[4];
			axiRd(`PDIO_STAT_OFF, d, `PDIO_RESP_OK);
			chkWord({30'h0, d[1:0]}, {30'h0, e2 ^ ~ctl[10], e1 ^ ~ctl[2]});
			axiRd(`PDIO_CTRL_OFF, d, `PDIO_RESP_OK);
			chkWord(d, ctl);
		end
		ext.setPins(1'b1, 1'b1);
		// pwm: pin one 3 low clocks in every 10, pin two 5, so 30 and 50 in any 100
		axiWr(`PDIO_P1PER_OFF, 32'h0000_000a, `PDIO_RESP_OK);
		axiWr(`PDIO_P1DUTY_OFF, 32'h0000_0003, `PDIO_RESP_OK);
		axiWr(`PDIO_P2PER_OFF, 32'h0000_000a, `PDIO_RESP_OK);
		axiWr(`PDIO_P2DUTY_OFF, 32'h0000_0005, `PDIO_RESP_OK);
		axiWr(`PDIO_CTRL_OFF, 32'h0000_1212, `PDIO_RESP_OK);
		cyc(20);
		cnt = 0;
		n = 0;
		repeat (100)
		begin
			@(negedge core_clk);
			if (pin1Out === 1'b0)
				cnt++;
			if (pin2Out === 1'b0)
				n++;
		end
		chkWord(cnt, 32'h0000_001e);
		chkWord(n, 32'h0000_0032);
		rstChk();
		axiRd(8'h1c, d, `PDIO_RESP_SLVERR);
		chkWord(d, 32'h0);
		axiWr(8'h20, 32'h1, `PDIO_RESP_SLVERR);
		pulseIn(1'b1, 1'b0);
		cyc(3);
		chkBit(protActive, 1'b1);
		chkBit(pin2Out, 1'b0);
		axiWr(`PDIO_CTRL_OFF, 32'h0000_0400, `PDIO_RESP_OK);
		cyc(3);
		chkBit(pin2Out, 1'b1);
		axiWr(`PDIO_CTRL_OFF, 32'h0, `PDIO_RESP_OK);
		// switching on while protected must not emit
		pulseIn(1'b0, 1'b1);
		cyc(10);
		chkBit(pin1Oe, 1'b0);
		pulseIn(1'b0, 1'b0);
		// a low just short of 30 us is ignored, a longer one clears
		ext.lowPulse(2995);
		cyc(10);
		chkBit(protActive, 1'b1);
		ext.lowPulse(3010);
		cyc(10);
		chkBit(protActive, 1'b0);
		chkBit(pin2Out, 1'b1);
		axiRd(`PDIO_STAT_OFF, d, `PDIO_RESP_OK);
		chkWord({27'h0, d[4:0]}, 32'h0000_0010);
		axiWr(`PDIO_STAT_OFF, 32'h0000_0010, `PDIO_RESP_OK);
		pulseIn(1'b0, 1'b1);
		n = 0;
		while (pin1Oe !== 1'b1 && n < 50)
		begin
			@(negedge core_clk);
			n++;
		end
		hung(n);
		cnt = 0;
		while (pin1Oe === 1'b1 && cnt < 4000)
		begin
			@(negedge core_clk);
			cnt++;
		end
		cyc(2);
		chkWord(cnt, 32'd3000);
		chkWord(ext.lastLow, 32'd3000);
		// own emitted low must not count as an outside clear
		cyc(10);
		axiRd(`PDIO_STAT_OFF, d, `PDIO_RESP_OK);
		chkWord({27'h0, d[4:0]}, 32'h0000_0000);
		pulseIn(1'b1, 1'b0);
		cyc(3);
		chkBit(protActive, 1'b1);
		axiWr(`PDIO_CMD_OFF, 32'h0000_0001, `PDIO_RESP_OK);
		cyc(3);
		chkBit(protActive, 1'b0);
		end_of_test();
	end
endmodule : tb_pdio_top
`default_nettype wire
